// File: design/lids_pkg.sv
// Constants for the line unit drive and scan register bank
package lids_pkg;
   // Register addresses on the processor port
   localparam logic [8:0] LIDS_ADDR_CONTROL = 9'h072;
   localparam logic [8:0] LIDS_ADDR_STATUS = 9'h073;
   localparam logic [8:0] LIDS_ADDR_GPIO_DIR = 9'h074;
   localparam logic [8:0] LIDS_ADDR_GPIO_DATA = 9'h075;
   // Control register field positions
   localparam int LIDS_BIT_REMOTE_LOOP = 0;
   localparam int LIDS_BIT_LOCAL_LOOP = 1;
   localparam int LIDS_BIT_ALL_ONES = 4;
   localparam int LIDS_BIT_EQ_BYPASS = 5;
   // Status register field positions
   localparam int LIDS_BIT_SIGNAL_LOST = 0;
   localparam int LIDS_BIT_LOCK_LOST = 1;
   localparam int LIDS_BIT_DRIVE_MON = 2;
   // Reset values and implemented-bit masks
   localparam logic [7:0] LIDS_CONTROL_RST = 8'h00;
   localparam logic [7:0] LIDS_CONTROL_MASK = 8'h33;
   localparam int LIDS_GPIO_W = 3;
   localparam logic [2:0] LIDS_GPIO_RST = 3'h0;
   localparam logic [7:0] LIDS_RDATA_RST = 8'h00;
endpackage

// File: design/lids_top.sv
// Line unit drive and scan register bank with general-purpose pins
// Functional notes
// - Bit 5 at 0x72 drives equalizer bypass
// - Bit 4 drives all-ones transmit command
// - Bit 1 drives local loop output
// - Remote loop taken from bit 0
// - Status bit 2 reads drive monitor
// - Status bit 1 reads loss of lock
// - Status bit 0 reads loss of signal
// - Signal-lost input declares loss of signal
// - Red alarm ORs three framer alarms
// - GPIO pins selectable input or output
// - Reset clears registers, tri-states outputs
`timescale 1ns/1ps
`default_nettype none
module lids_top
   import lids_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [8:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_rdata_oe,
   input wire logic i_drive_monitor_in,
   input wire logic i_lock_lost_in,
   input wire logic i_signal_lost_in,
   input wire logic i_framer_signal_loss,
   input wire logic i_framer_out_of_frame,
   input wire logic i_framer_alarm_indication,
   output logic o_eq_bypass_out,
   output logic o_all_ones_cmd_out,
   output logic o_local_loop_out,
   output logic o_remote_loop_out,
   output logic o_los_declared,
   output logic o_red_alarm_out,
   output logic o_line_oe,
   input wire logic [2:0] i_gpio,
   output logic [2:0] o_gpio,
   output logic [2:0] o_gpio_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Decode

   // Address match gated by chip select and a strobe
   // Strobes are levels, so a write held for several cycles rewrites the same value
   function automatic logic hit(input logic [8:0] addr, input logic [8:0] target, input logic strobe_n,
                                input logic cs_n);
      hit = !cs_n && !strobe_n && (addr == target);
   endfunction

   logic wr_ctrl; // Control register write this cycle
   logic wr_dir; // GPIO direction write
   logic wr_gdata; // GPIO output data write
   logic wr_status; // Ignored write to the read-only status
   logic rd_any; // Any read strobe with select
   assign wr_ctrl = hit(i_addr, LIDS_ADDR_CONTROL, i_wr_n, i_cs_n);
   assign wr_dir = hit(i_addr, LIDS_ADDR_GPIO_DIR, i_wr_n, i_cs_n);
   assign wr_gdata = hit(i_addr, LIDS_ADDR_GPIO_DATA, i_wr_n, i_cs_n);
   assign wr_status = hit(i_addr, LIDS_ADDR_STATUS, i_wr_n, i_cs_n);
   assign rd_any = !i_cs_n && !i_rd_n;

   ////////////////////////////////////////////////////////////////////////
   // Register state

   logic [7:0] ctrl_q, ctrl_d; // Drive register, masked bits only
   logic [2:0] dir_q, dir_d; // GPIO direction, 1 = output
   logic [2:0] gout_q, gout_d; // GPIO output levels
   logic [7:0] rdata_q, rdata_d; // Read data holding flop
   logic rdoe_q, rdoe_d; // Data bus drive enable
   logic los_q, los_d; // Loss of signal declaration
   logic red_q, red_d; // Red alarm
   logic oe_q, oe_d; // Line outputs enabled once out of reset

   // Next-state for the register bank; status writes fall through untouched
   always_comb
   begin
      ctrl_d = ctrl_q;
      dir_d = dir_q;
      gout_d = gout_q;
      rdata_d = rdata_q;
      rdoe_d = rd_any;
      oe_d = 1'b1;
      if (wr_ctrl)
      begin
         ctrl_d = i_wdata & LIDS_CONTROL_MASK;
      end
      if (wr_dir)
      begin
         dir_d = i_wdata[2:0];
      end
      if (wr_gdata)
      begin
         gout_d = i_wdata[2:0];
      end
      // Read mux; unmapped addresses read zero
      if (rd_any)
      begin
         unique case (i_addr)
            LIDS_ADDR_CONTROL: rdata_d = ctrl_q;
            LIDS_ADDR_STATUS: rdata_d = {5'h00, i_drive_monitor_in, i_lock_lost_in, i_signal_lost_in};
            LIDS_ADDR_GPIO_DIR: rdata_d = {5'h00, dir_q};
            // input pins read back where direction is input
            LIDS_ADDR_GPIO_DATA: rdata_d = {5'h00, (i_gpio & ~dir_q) | (gout_q & dir_q)};
            default: rdata_d = 8'h00;
         endcase
      end
      los_d = i_signal_lost_in;
      red_d = i_framer_signal_loss | i_framer_out_of_frame | i_framer_alarm_indication;
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ctrl_q <= LIDS_CONTROL_RST;
         dir_q <= LIDS_GPIO_RST;
         gout_q <= LIDS_GPIO_RST;
         rdata_q <= LIDS_RDATA_RST;
         rdoe_q <= 1'b0;
         los_q <= 1'b0;
         red_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         dir_q <= dir_d;
         gout_q <= gout_d;
         rdata_q <= rdata_d;
         rdoe_q <= rdoe_d;
         los_q <= los_d;
         red_q <= red_d;
         oe_q <= oe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops

   assign o_eq_bypass_out = ctrl_q[LIDS_BIT_EQ_BYPASS];
   assign o_all_ones_cmd_out = ctrl_q[LIDS_BIT_ALL_ONES];
   assign o_local_loop_out = ctrl_q[LIDS_BIT_LOCAL_LOOP];
   // remote loop on its own bit
   assign o_remote_loop_out = ctrl_q[LIDS_BIT_REMOTE_LOOP];
   assign o_rdata = rdata_q;
   assign o_rdata_oe = rdoe_q;
   assign o_los_declared = los_q;
   assign o_red_alarm_out = red_q;
   assign o_line_oe = oe_q;
   assign o_gpio = gout_q;
   // Direction resets to input, so pins float during and after reset
   assign o_gpio_oe = dir_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge i_clk); endclocking
   // Reset may drop at the very edge that the flops still see it high; oe_q is
   // low on that edge only, so the checks skip it rather than compare against
   // values sampled before the flops were cleared
   default disable iff (i_sys_rst || !oe_q);

   eq_bypass_a: assert property (wr_ctrl |=> o_eq_bypass_out == $past(i_wdata[5]))
      else $error("equalizer bypass does not follow write");
   all_ones_a: assert property (wr_ctrl |=> o_all_ones_cmd_out == $past(i_wdata[4]))
      else $error("all-ones command does not follow write");
   local_loop_a: assert property (wr_ctrl |=> o_local_loop_out == $past(i_wdata[1]))
      else $error("local loop does not follow write");
   remote_loop_a: assert property (wr_ctrl |=> o_remote_loop_out == $past(i_wdata[0]))
      else $error("remote loop does not follow write");
   status_read_a: assert property ((rd_any && i_addr == LIDS_ADDR_STATUS) |=>
      (o_rdata == {5'h00, $past(i_drive_monitor_in), $past(i_lock_lost_in), $past(i_signal_lost_in)}) && o_rdata_oe)
      else $error("status read returns wrong levels");
   los_declare_a: assert property (i_signal_lost_in |=> o_los_declared)
      else $error("loss of signal not declared");
   red_alarm_a: assert property (##1 o_red_alarm_out == $past(i_framer_signal_loss | i_framer_out_of_frame |
      i_framer_alarm_indication))
      else $error("red alarm is not the OR of framer alarms");
   gpio_out_a: assert property (wr_gdata |=> o_gpio == $past(i_wdata[2:0]))
      else $error("gpio output does not follow write");
   status_ro_a: assert property ((wr_status && !wr_ctrl) |=> ctrl_q == $past(ctrl_q))
      else $error("status write disturbed control");
   unused_zero_a: assert property ((ctrl_q & ~LIDS_CONTROL_MASK) == 8'h00)
      else $error("unimplemented control bits set");
   line_oe_a: assert property (##1 o_line_oe)
      else $error("line outputs not enabled after reset");
   // Everything quiet while reset has been held over a whole cycle
   reset_quiet_a: assert property (disable iff (1'b0) ($past(i_sys_rst) && i_sys_rst) |->
      (!o_line_oe && !o_eq_bypass_out && !o_all_ones_cmd_out && !o_local_loop_out && !o_remote_loop_out &&
      !o_los_declared && !o_red_alarm_out && !o_rdata_oe && (o_gpio_oe == 3'h0) && (o_gpio == 3'h0) &&
      (o_rdata == 8'h00)))
      else $error("outputs active during reset");
   los_clear_a: assert property (!i_signal_lost_in |=> !o_los_declared)
      else $error("loss of signal declared without cause");
   // Bus drive enable follows the read strobe level, one cycle later
   rd_enable_a: assert property (##1 o_rdata_oe == $past(rd_any))
      else $error("read data enable out of step with read strobe");

   loop_cover: cover property (wr_ctrl ##1 (o_local_loop_out && o_remote_loop_out));
   red_cover: cover property (!o_red_alarm_out ##1 o_red_alarm_out);
   status_cover: cover property ((rd_any && i_addr == LIDS_ADDR_STATUS) ##1 o_rdata[LIDS_BIT_DRIVE_MON]);
   gpio_cover: cover property (wr_dir ##1 (o_gpio_oe != 3'h0));
   rdoe_cover: cover property (o_rdata_oe ##1 !o_rdata_oe);

endmodule
`default_nettype wire

// File: tb/lids_line_model.sv
// Stand-in for the external line unit that reports its status levels
`timescale 1ns/1ps
`default_nettype none
module lids_line_model
(
   input wire logic i_clk,
   input wire logic [2:0] i_status,
   output logic o_drive_monitor_in,
   output logic o_lock_lost_in,
   output logic o_signal_lost_in
);
   ////////////////////////////////////////////////////////////////
   // status pins follow line
   // Registered, so levels change only after a clock edge, like a real part
   always_ff @(posedge i_clk)
   begin
      {o_drive_monitor_in, o_lock_lost_in, o_signal_lost_in} <= i_status;
   end
endmodule
`default_nettype wire

// File: tb/test_line_interface_drive_scan.sv
// Self-checking bench for the line unit drive and scan bank
`timescale 1ns/1ps
`default_nettype none
module test_line_interface_drive_scan;
   import lids_pkg::*;
   logic clk = 1'h0, rst = 1'h1, cs_n = 1'h1, rd_n = 1'h1, wr_n = 1'h1;
   logic [8:0] addr = 9'h000;
   logic [7:0] wdata = 8'h00, rdata;
   logic [2:0] st = 3'h0, fr = 3'h0, gpi = 3'h0, gpo, gpoe, pin;
   logic mon, lkl, sgl, rdoe, eq, ones, ll, rl, losd, alarm, loe;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   // Pin level: our driver wins where the block is not driving
   assign pin = (gpoe & gpo) | (~gpoe & gpi);
   lids_top lids_top_inst (.i_clk(clk), .i_sys_rst(rst), .i_cs_n(cs_n), .i_rd_n(rd_n),
      .i_wr_n(wr_n), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rdata_oe(rdoe),
      .i_drive_monitor_in(mon), .i_lock_lost_in(lkl), .i_signal_lost_in(sgl),
      .i_framer_signal_loss(fr[2]), .i_framer_out_of_frame(fr[1]), .i_framer_alarm_indication(fr[0]),
      .o_eq_bypass_out(eq), .o_all_ones_cmd_out(ones), .o_local_loop_out(ll), .o_remote_loop_out(rl),
      .o_los_declared(losd), .o_red_alarm_out(alarm), .o_line_oe(loe), .i_gpio(pin), .o_gpio(gpo),
      .o_gpio_oe(gpoe));
   lids_line_model lids_line_model_inst (.i_clk(clk), .i_status(st), .o_drive_monitor_in(mon),
      .o_lock_lost_in(lkl), .o_signal_lost_in(sgl));
   ////////////////////////////////////////////////////////////////
   // 125 MHz clock and hang guard; whole run is about 110 cycles
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One register cycle; strobes held across the taking edge
   task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
      @(posedge clk);
      cs_n <= 1'h0;
      wr_n <= ~w;
      rd_n <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      cs_n <= 1'h1;
      wr_n <= 1'h1;
      rd_n <= 1'h1;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////
   // Drive bits, masking, unmapped read
   task automatic t_control();
      bus(1'h1, LIDS_ADDR_CONTROL, 8'hff);
      bus(1'h0, LIDS_ADDR_CONTROL, 8'h00);
      chk(rdata, 8'h33);
      chk({7'h00, rdoe}, 8'h01);
      @(posedge clk);
      #1;
      chk({7'h00, rdoe}, 8'h00);
      bus(1'h0, 9'h1ff, 8'h00);
      chk(rdata, 8'h00);
      bus(1'h1, LIDS_ADDR_CONTROL, 8'h21);
      chk({4'h0, eq, ones, ll, rl}, 8'h09);
      bus(1'h1, LIDS_ADDR_CONTROL, 8'h12);
      chk({4'h0, eq, ones, ll, rl}, 8'h06);
      $display("t_control done");
   endtask
   // Every status combination, with an ignored write first
   task automatic t_status();
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk) st <= i[2:0];
         repeat (2) @(posedge clk);
         bus(1'h1, LIDS_ADDR_STATUS, 8'hff);
         bus(1'h0, LIDS_ADDR_STATUS, 8'h00);
         chk(rdata, {5'h00, i[2:0]});
         chk({7'h00, losd}, {7'h00, i[0]});
      end
      $display("t_status done");
   endtask
   // Every framer alarm combination
   task automatic t_alarm();
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk) fr <= i[2:0];
         @(posedge clk);
         #1;
         chk({7'h00, alarm}, {7'h00, |i[2:0]});
      end
      $display("t_alarm done");
   endtask
   // Mixed directions: pins 0 and 2 out, pin 1 in
   task automatic t_gpio();
      bus(1'h1, LIDS_ADDR_GPIO_DIR, 8'h05);
      bus(1'h1, LIDS_ADDR_GPIO_DATA, 8'h03);
      @(posedge clk) gpi <= 3'h2;
      bus(1'h0, LIDS_ADDR_GPIO_DATA, 8'h00);
      chk({2'h0, gpoe, gpo}, 8'h2b);
      chk(rdata, 8'h03);
      @(posedge clk) gpi <= 3'h0;
      bus(1'h0, LIDS_ADDR_GPIO_DATA, 8'h00);
      chk(rdata, 8'h01);
      $display("t_gpio done");
   endtask
   // Reset in mid-run clears and tri-states
   task automatic t_reset();
      bus(1'h1, LIDS_ADDR_CONTROL, 8'hff);
      @(posedge clk) rst <= 1'h1;
      @(posedge clk);
      #1;
      chk({loe, eq, ones, ll, rl, gpoe}, 8'h00);
      chk({losd, alarm, rdoe, gpo, 2'h0}, 8'h00);
      chk(rdata, 8'h00);
      @(posedge clk) rst <= 1'h0;
      bus(1'h0, LIDS_ADDR_CONTROL, 8'h00);
      chk(rdata, LIDS_CONTROL_RST);
      chk({7'h00, loe}, 8'h01);
      $display("t_reset done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      t_control();
      t_status();
      t_alarm();
      t_gpio();
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire
